// ==== src/irq_ctrl_cfg.svh ====
// Purpose: named constants of the three-level interrupt controller
// Assumes: included by bare name from the controller only
// Notes: byte offsets on the AHB-Lite register bus, bit positions, vectors
`ifndef IRQ_CTRL_CFG_SVH
`define IRQ_CTRL_CFG_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define ADDR_TIMER_CTRL 8'h00
`define ADDR_IRQ_EN 8'h04
`define ADDR_IRQ_PRIO 8'h08
`define ADDR_EXT_IRQ_EN 8'h0C
`define ADDR_EXT_IRQ_PRIO 8'h10
`define ADDR_EXT_IRQ_FLAG 8'h14
`define ADDR_EXT_IRQ_CTRL 8'h18
`define ADDR_AUX_MASK 8'h1C
`define ADDR_AUX_RAW 8'h20
`define ADDR_SWAP_CTRL 8'h24
`define ADDR_BKPT_CTRL 8'h28
`define ADDR_SERIAL0_CTRL 8'h2C
`define ADDR_SERIAL1_CTRL 8'h30
`define ADDR_TIMER2_CTRL 8'h34
`define ADDR_EVT_STAT 8'h38
`define ADDR_EVT_MASK 8'h3C

// ----------------------------------------------------------------------
// bit positions
// ----------------------------------------------------------------------
`define TC_T1_FLAG 3'h7
`define TC_T1_RUN 3'h6
`define TC_T0_FLAG 3'h5
`define TC_T0_RUN 3'h4
`define TC_X1_FLAG 3'h3
`define TC_X1_EDGE 3'h2
`define TC_X0_FLAG 3'h1
`define TC_X0_EDGE 3'h0
`define EN_GLOBAL 3'h7
`define XC_AUX_EN 3'h5
`define XC_AUX_FLAG 3'h4
`define XC_WDOG_FLAG 3'h3
`define BP_FLAG 3'h7
`define BP_EN 3'h0
`define SER_RX 1'h0
`define SER_TX 1'h1
`define T2_FLAG 3'h7
`define XF_LO 3'h4

// ----------------------------------------------------------------------
// vector addresses and interrupt numbers
// ----------------------------------------------------------------------
`define VEC_AUX 8'h33
`define VEC_X0 8'h03
`define VEC_T0 8'h0B
`define VEC_X1 8'h13
`define VEC_T1 8'h1B
`define VEC_S0 8'h23
`define VEC_T2 8'h2B
`define VEC_S1 8'h3B
`define VEC_X2 8'h43
`define VEC_X3 8'h4B
`define VEC_X4 8'h53
`define VEC_X5 8'h5B
`define VEC_WDOG 8'h63
`define NUM_AUX 4'h6
`define NUM_S1 4'h7
`define RESET_BYTE 8'h00

`endif

// ==== src/irq_ctrl_pkg.sv ====
// Purpose: types shared by the interrupt controller
// Assumes: nothing
// Notes: source index equals the fixed natural service order
`default_nettype none
package irq_ctrl_pkg;
  // source index, lowest is served first within a level
  typedef enum logic [3:0] {
    SRC_AUX = 4'h0, SRC_X0 = 4'h1, SRC_T0 = 4'h2, SRC_X1 = 4'h3, SRC_T1 = 4'h4,
    SRC_S0 = 4'h5, SRC_T2 = 4'h6, SRC_S1 = 4'h7, SRC_X2 = 4'h8, SRC_X3 = 4'h9,
    SRC_X4 = 4'hA, SRC_X5 = 4'hB, SRC_WDOG = 4'hC
  } src_t;
  typedef logic [12:0] src_vec_t;
endpackage : irq_ctrl_pkg
`default_nettype wire

// ==== src/three_level_irq_controller.sv ====
// Purpose: three-level interrupt controller with AHB-Lite register slave
// Assumes: event inputs and pins synchronous to sys_clk; core pulses vector_ack
// Notes: zero wait states; reads are captured in the address phase
// Operation
// RL1: three levels: auxiliary, high, low
// RL2: per-source flag, enable, priority, vector
// RL3: nine auxiliary sources share vector 33h, number 6
// RL4: auxiliary mask bit order as listed
// RL5: bit 0 shared with breakpoint flag/enable
// RL6: auxiliary flag set; taken only when enabled
// RL7: swap set: raw reads live, mask stored
// RL8: swap clear: raw reads mask, mask live
// RL9: global enable gates non-auxiliary sources
// RL10: fixed vector addresses per source
// RL11: fixed natural order within a level
// RL12: enable and priority bit placement
// RL13: edge external flags cleared on vectoring
// RL14: level externals 0/1 follow pin
// RL15: timer 0/1 flags cleared on vectoring
// RL16: external 2-5 and watchdog flag placement
// RL17: timer 1 vector at 1Bh
// RL18: serial requests on receive or transmit flag
`include "irq_ctrl_cfg.svh"
`default_nettype none
module three_level_irq_controller (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [5:0] ext_pin_n,
  input wire logic timer0_ovf,
  input wire logic timer1_ovf,
  input wire logic timer2_ovf,
  input wire logic [1:0] serial0_evt,
  input wire logic [1:0] serial1_evt,
  input wire logic wdog_evt,
  input wire logic bkpt_evt,
  input wire logic [7:0] aux_evt,
  input wire logic vector_ack,
  output logic irq_req,
  output logic [7:0] irq_vec,
  output logic [3:0] irq_num,
  output logic [3:0] irq_src,
  output logic irq_out
);

  // ----------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------
  logic wr_q;
  logic [7:0] waddr_q;
  logic addr_ok;
  logic we_any;
  logic [7:0] rd_d;
  logic [7:0] wb;
  // register state
  logic [7:0] timer_ctrl_reg_q;
  logic [7:0] irq_en_reg_q;
  logic [6:0] irq_prio_reg_q;
  logic [4:0] ext_irq_en_reg_q;
  logic [4:0] ext_irq_prio_reg_q;
  logic [3:0] ext_irq_flag_q;
  logic aux_irq_en_q;
  logic aux_irq_q;
  logic wdog_irq_flag_q;
  logic [7:0] aux_mask_reg_q;
  logic readback_swap_q;
  logic bkpt_flag_q;
  logic bkpt_en_q;
  logic [1:0] serial0_ctrl_q;
  logic [1:0] serial1_ctrl_q;
  logic timer2_ovf_flag_q;
  irq_ctrl_pkg::src_vec_t evt_stat_q;
  irq_ctrl_pkg::src_vec_t evt_mask_q;
  irq_ctrl_pkg::src_vec_t pend_prev_q;
  logic [5:0] pin_prev_q;
  // arbitration
  irq_ctrl_pkg::src_vec_t pend;
  irq_ctrl_pkg::src_vec_t high;
  irq_ctrl_pkg::src_vec_t clr;
  logic [11:0] flags;
  logic [11:0] enables;
  logic win_ok;
  irq_ctrl_pkg::src_t win_idx;
  logic [5:0] pin_fall;
  logic aux_live;

  assign addr_ok = hsel && htrans[1] && hready && (haddr[31:8] == 24'h000000);
  assign we_any = wr_q;
  assign wb = hwdata[7:0];

  // address phase capture, fixed OKAY and no wait states
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      wr_q <= 1'b0;
      waddr_q <= `RESET_BYTE;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      wr_q <= addr_ok && hwrite;
      waddr_q <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // read mux, captured at the address phase edge
  always_comb
  begin
    rd_d = `RESET_BYTE;
    unique case (haddr[7:0])
      `ADDR_TIMER_CTRL: rd_d = timer_ctrl_reg_q;
      `ADDR_IRQ_EN: rd_d = irq_en_reg_q;
      `ADDR_IRQ_PRIO: rd_d = {1'b0, irq_prio_reg_q};
      `ADDR_EXT_IRQ_EN: rd_d = {3'h0, ext_irq_en_reg_q};
      `ADDR_EXT_IRQ_PRIO: rd_d = {3'h0, ext_irq_prio_reg_q};
      `ADDR_EXT_IRQ_FLAG: rd_d = {ext_irq_flag_q, 4'h0}; // RL16
      `ADDR_EXT_IRQ_CTRL: rd_d = {2'h0, aux_irq_en_q, aux_irq_q, wdog_irq_flag_q, 3'h0};
      `ADDR_AUX_MASK: rd_d = readback_swap_q ? aux_mask_reg_q : aux_evt; // RL7 RL8
      `ADDR_AUX_RAW: rd_d = readback_swap_q ? aux_evt : aux_mask_reg_q; // RL7 RL8
      `ADDR_SWAP_CTRL: rd_d = {7'h00, readback_swap_q};
      `ADDR_BKPT_CTRL: rd_d = {bkpt_flag_q, 6'h00, bkpt_en_q}; // RL5
      `ADDR_SERIAL0_CTRL: rd_d = {6'h00, serial0_ctrl_q};
      `ADDR_SERIAL1_CTRL: rd_d = {6'h00, serial1_ctrl_q};
      `ADDR_TIMER2_CTRL: rd_d = {timer2_ovf_flag_q, 7'h00};
      default: rd_d = `RESET_BYTE;
    endcase
  end

  // read data register; status and mask are 13 bits wide
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      hrdata <= 32'h00000000;
    else if (addr_ok && !hwrite)
    begin
      if (haddr[7:0] == `ADDR_EVT_STAT)
        hrdata <= {19'h00000, evt_stat_q};
      else if (haddr[7:0] == `ADDR_EVT_MASK)
        hrdata <= {19'h00000, evt_mask_q};
      else
        hrdata <= {24'h000000, rd_d};
    end
  end

  // ----------------------------------------------------------------------
  // plain control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      irq_en_reg_q <= `RESET_BYTE;
      irq_prio_reg_q <= 7'h00;
      ext_irq_en_reg_q <= 5'h00;
      ext_irq_prio_reg_q <= 5'h00;
      aux_irq_en_q <= 1'b0;
      aux_mask_reg_q <= `RESET_BYTE;
      readback_swap_q <= 1'b0;
      bkpt_en_q <= 1'b0;
      evt_mask_q <= 13'h0000;
    end
    else if (we_any)
    begin
      unique case (waddr_q)
        `ADDR_IRQ_EN: irq_en_reg_q <= wb; // RL12
        `ADDR_IRQ_PRIO: irq_prio_reg_q <= wb[6:0]; // RL12
        `ADDR_EXT_IRQ_EN: ext_irq_en_reg_q <= wb[4:0]; // RL12
        `ADDR_EXT_IRQ_PRIO: ext_irq_prio_reg_q <= wb[4:0]; // RL12
        `ADDR_EXT_IRQ_CTRL: aux_irq_en_q <= wb[`XC_AUX_EN];
        `ADDR_AUX_MASK: aux_mask_reg_q <= wb; // RL4
        `ADDR_SWAP_CTRL: readback_swap_q <= wb[0];
        `ADDR_BKPT_CTRL: bkpt_en_q <= wb[`BP_EN]; // RL5
        `ADDR_EVT_MASK: evt_mask_q <= hwdata[12:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // request flags; hardware set wins over software or vectoring clear
  // ----------------------------------------------------------------------
  assign pin_fall = pin_prev_q & ~ext_pin_n;

  // pin history for falling edge detection
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      pin_prev_q <= 6'h3F;
    else
      pin_prev_q <= ext_pin_n;
  end

  // timer control: externals 0/1 and timers 0/1
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      timer_ctrl_reg_q <= `RESET_BYTE;
    else
    begin
      if (we_any && waddr_q == `ADDR_TIMER_CTRL)
      begin
        timer_ctrl_reg_q[`TC_T1_RUN] <= wb[`TC_T1_RUN];
        timer_ctrl_reg_q[`TC_T0_RUN] <= wb[`TC_T0_RUN];
        timer_ctrl_reg_q[`TC_X1_EDGE] <= wb[`TC_X1_EDGE];
        timer_ctrl_reg_q[`TC_X0_EDGE] <= wb[`TC_X0_EDGE];
      end
      // RL15
      timer_ctrl_reg_q[`TC_T0_FLAG] <= timer0_ovf | (((we_any && waddr_q == `ADDR_TIMER_CTRL)
        ? wb[`TC_T0_FLAG] : timer_ctrl_reg_q[`TC_T0_FLAG]) & ~clr[irq_ctrl_pkg::SRC_T0]);
      timer_ctrl_reg_q[`TC_T1_FLAG] <= timer1_ovf | (((we_any && waddr_q == `ADDR_TIMER_CTRL)
        ? wb[`TC_T1_FLAG] : timer_ctrl_reg_q[`TC_T1_FLAG]) & ~clr[irq_ctrl_pkg::SRC_T1]);
      // RL13 RL14
      if (timer_ctrl_reg_q[`TC_X0_EDGE])
        timer_ctrl_reg_q[`TC_X0_FLAG] <= pin_fall[0] | (((we_any && waddr_q == `ADDR_TIMER_CTRL)
          ? wb[`TC_X0_FLAG] : timer_ctrl_reg_q[`TC_X0_FLAG]) & ~clr[irq_ctrl_pkg::SRC_X0]);
      else
        timer_ctrl_reg_q[`TC_X0_FLAG] <= ~ext_pin_n[0];
      if (timer_ctrl_reg_q[`TC_X1_EDGE])
        timer_ctrl_reg_q[`TC_X1_FLAG] <= pin_fall[1] | (((we_any && waddr_q == `ADDR_TIMER_CTRL)
          ? wb[`TC_X1_FLAG] : timer_ctrl_reg_q[`TC_X1_FLAG]) & ~clr[irq_ctrl_pkg::SRC_X1]);
      else
        timer_ctrl_reg_q[`TC_X1_FLAG] <= ~ext_pin_n[1];
    end
  end

  // externals 2 to 5, edge triggered, cleared on vectoring
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      ext_irq_flag_q <= 4'h0;
    else
      ext_irq_flag_q <= pin_fall[5:2] | (((we_any && waddr_q == `ADDR_EXT_IRQ_FLAG)
        ? wb[7:`XF_LO] : ext_irq_flag_q) & ~clr[11:8]); // RL13 RL16
  end

  // watchdog, serial and timer 2 flags, cleared by software only
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      wdog_irq_flag_q <= 1'b0;
      serial0_ctrl_q <= 2'h0;
      serial1_ctrl_q <= 2'h0;
      timer2_ovf_flag_q <= 1'b0;
    end
    else
    begin
      wdog_irq_flag_q <= wdog_evt | ((we_any && waddr_q == `ADDR_EXT_IRQ_CTRL)
        ? wb[`XC_WDOG_FLAG] : wdog_irq_flag_q); // RL16
      serial0_ctrl_q <= serial0_evt | ((we_any && waddr_q == `ADDR_SERIAL0_CTRL)
        ? wb[1:0] : serial0_ctrl_q); // RL18
      serial1_ctrl_q <= serial1_evt | ((we_any && waddr_q == `ADDR_SERIAL1_CTRL)
        ? wb[1:0] : serial1_ctrl_q); // RL18
      timer2_ovf_flag_q <= timer2_ovf | ((we_any && waddr_q == `ADDR_TIMER2_CTRL)
        ? wb[`T2_FLAG] : timer2_ovf_flag_q);
    end
  end

  // ----------------------------------------------------------------------
  // auxiliary group
  // ----------------------------------------------------------------------
  assign aux_live = |(aux_evt & aux_mask_reg_q) | (bkpt_flag_q & bkpt_en_q); // RL4 RL5 RL6

  // breakpoint flag and shared auxiliary flag
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      bkpt_flag_q <= 1'b0;
      aux_irq_q <= 1'b0;
    end
    else
    begin
      bkpt_flag_q <= bkpt_evt | ((we_any && waddr_q == `ADDR_BKPT_CTRL)
        ? wb[`BP_FLAG] : bkpt_flag_q); // RL5
      aux_irq_q <= aux_live; // RL6
    end
  end

  // ----------------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------------
  assign flags = {wdog_irq_flag_q, ext_irq_flag_q, |serial1_ctrl_q, timer2_ovf_flag_q,
    |serial0_ctrl_q, timer_ctrl_reg_q[`TC_T1_FLAG], timer_ctrl_reg_q[`TC_X1_FLAG],
    timer_ctrl_reg_q[`TC_T0_FLAG], timer_ctrl_reg_q[`TC_X0_FLAG]}; // RL2 RL18
  assign enables = {ext_irq_en_reg_q, irq_en_reg_q[6:0]}; // RL12
  assign pend = {flags & enables & {12{irq_en_reg_q[`EN_GLOBAL]}}, aux_irq_q & aux_irq_en_q}; // RL6 RL9
  assign high = {ext_irq_prio_reg_q, irq_prio_reg_q, 1'b1}; // RL1 RL3
  assign clr = (vector_ack && irq_req) ? (13'h0001 << irq_src) : 13'h0000; // RL13 RL15

  // lowest index at the highest level wins
  always_comb
  begin
    logic hit_hi;
    hit_hi = 1'b0;
    win_ok = 1'b0;
    win_idx = irq_ctrl_pkg::SRC_AUX;
    for (int i = 12; i >= 0; i--)
    begin
      if (pend[i] && high[i])
      begin
        hit_hi = 1'b1;
        win_idx = irq_ctrl_pkg::src_t'(i[3:0]); // RL11
      end
    end
    for (int i = 12; i >= 0; i--)
    begin
      if (pend[i] && !hit_hi)
        win_idx = irq_ctrl_pkg::src_t'(i[3:0]); // RL1 RL11
    end
    win_ok = |pend;
  end

  // vector address of each source
  function automatic logic [7:0] vec_of(input irq_ctrl_pkg::src_t s);
    unique case (s)
      irq_ctrl_pkg::SRC_AUX: vec_of = `VEC_AUX; // RL3
      irq_ctrl_pkg::SRC_X0: vec_of = `VEC_X0; // RL10
      irq_ctrl_pkg::SRC_T0: vec_of = `VEC_T0;
      irq_ctrl_pkg::SRC_X1: vec_of = `VEC_X1;
      irq_ctrl_pkg::SRC_T1: vec_of = `VEC_T1; // RL17
      irq_ctrl_pkg::SRC_S0: vec_of = `VEC_S0;
      irq_ctrl_pkg::SRC_T2: vec_of = `VEC_T2;
      irq_ctrl_pkg::SRC_S1: vec_of = `VEC_S1;
      irq_ctrl_pkg::SRC_X2: vec_of = `VEC_X2;
      irq_ctrl_pkg::SRC_X3: vec_of = `VEC_X3;
      irq_ctrl_pkg::SRC_X4: vec_of = `VEC_X4;
      irq_ctrl_pkg::SRC_X5: vec_of = `VEC_X5;
      irq_ctrl_pkg::SRC_WDOG: vec_of = `VEC_WDOG;
      default: vec_of = `VEC_AUX;
    endcase
  endfunction : vec_of

  // interrupt number: auxiliary is 6, sources below it shift by one
  function automatic logic [3:0] num_of(input irq_ctrl_pkg::src_t s);
    if (s == irq_ctrl_pkg::SRC_AUX)
      num_of = `NUM_AUX; // RL3
    else if (s < irq_ctrl_pkg::SRC_S1)
      num_of = 4'(s - 4'h1);
    else
      num_of = 4'(s);
  endfunction : num_of

  // request to the core, dropped for the cycle after an acknowledge
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      irq_req <= 1'b0;
      irq_vec <= `RESET_BYTE;
      irq_num <= 4'h0;
      irq_src <= 4'h0;
    end
    else
    begin
      irq_req <= win_ok && !(vector_ack && irq_req);
      irq_vec <= vec_of(win_idx);
      irq_num <= num_of(win_idx);
      irq_src <= win_idx;
    end
  end

  // ----------------------------------------------------------------------
  // event status, mask and interrupt output
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      pend_prev_q <= 13'h0000;
      evt_stat_q <= 13'h0000;
      irq_out <= 1'b0;
    end
    else
    begin
      pend_prev_q <= pend;
      evt_stat_q <= (pend & ~pend_prev_q) | (evt_stat_q &
        ~((we_any && waddr_q == `ADDR_EVT_STAT) ? hwdata[12:0] : 13'h0000));
      irq_out <= |(evt_stat_q & evt_mask_q);
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence rd_mask_s;
    addr_ok && !hwrite && haddr[7:0] == `ADDR_AUX_MASK;
  endsequence
  sequence rd_raw_s;
    addr_ok && !hwrite && haddr[7:0] == `ADDR_AUX_RAW;
  endsequence

  global_gate_a: assert property (irq_req && irq_src != irq_ctrl_pkg::SRC_AUX |-> $past(irq_en_reg_q[7])) // RL9
    else $error("non-auxiliary request while globally disabled");
  aux_vector_a: assert property (irq_req && irq_src == irq_ctrl_pkg::SRC_AUX |-> irq_vec == 8'h33 && irq_num == 4'h6) // RL3
    else $error("auxiliary vector or number wrong");
  aux_first_a: assert property (aux_irq_q && aux_irq_en_q && !(vector_ack && irq_req) |=> irq_req && irq_src == 4'h0) // RL1
    else $error("auxiliary request not served first");
  timer1_vec_a: assert property (irq_req && irq_src == irq_ctrl_pkg::SRC_T1 |-> irq_vec == 8'h1B && irq_num == 4'h3) // RL17
    else $error("timer 1 vector wrong");
  edge_clear_a: assert property (vector_ack && irq_req && irq_src == irq_ctrl_pkg::SRC_X0
    && timer_ctrl_reg_q[0] && !pin_fall[0] && !wr_q |=> !timer_ctrl_reg_q[1]) // RL13
    else $error("edge external 0 flag not cleared on vectoring");
  level_track_a: assert property (!timer_ctrl_reg_q[0] |=> timer_ctrl_reg_q[1] == !$past(ext_pin_n[0])) // RL14
    else $error("level external 0 flag does not follow pin");
  timer_clear_a: assert property (vector_ack && irq_req && irq_src == irq_ctrl_pkg::SRC_T0
    && !timer0_ovf && !wr_q |=> !timer_ctrl_reg_q[5] ##1 irq_src != irq_ctrl_pkg::SRC_T0 || !irq_req) // RL15
    else $error("timer 0 flag not cleared on vectoring");
  swap_set_a: assert property (rd_mask_s ##0 readback_swap_q |=> hrdata[7:0] == $past(aux_mask_reg_q)) // RL7
    else $error("mask read wrong with swap set");
  swap_clear_a: assert property (rd_raw_s ##0 !readback_swap_q |=> hrdata[7:0] == $past(aux_mask_reg_q)) // RL8
    else $error("raw read wrong with swap clear");
  aux_flag_a: assert property ((aux_evt & aux_mask_reg_q) != 8'h00 |=> aux_irq_q) // RL6
    else $error("enabled auxiliary event did not set flag");
  serial_req_a: assert property (serial0_ctrl_q[1] && irq_en_reg_q[7] && irq_en_reg_q[4] |-> pend[5]) // RL18
    else $error("serial 0 transmit flag not requesting");

endmodule : three_level_irq_controller
`default_nettype wire

// ==== tb/irq_core_model.sv ====
// Purpose: behavioural core taking interrupt vectors
// Assumes: irq_req and irq_vec are registered by the controller
// Notes: acks after ack_dly + 1 cycles of request while ack_go is high
`default_nettype none
module irq_core_model (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic irq_req,
  input wire logic [7:0] irq_vec,
  input wire logic ack_go,
  input wire logic [1:0] ack_dly,
  output logic vector_ack,
  output logic [7:0] taken_vec,
  output logic [7:0] taken_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_q;
  // ---------------------------------------------------------------
  // vector handshake
  // ---------------------------------------------------------------
  // one-cycle ack, never back to back, prompt or slow
  always_ff @(posedge sys_clk)
  begin
    if (srst || !ack_go || !irq_req || vector_ack)
    begin
      vector_ack <= 1'b0;
      wait_q <= 2'h0;
    end
    else
    begin
      vector_ack <= (wait_q == ack_dly);
      wait_q <= wait_q + 2'h1;
    end
  end
  // vector seen at the edge the core takes it
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      taken_vec <= 8'h00;
      taken_cnt <= 8'h00;
    end
    else if (vector_ack && irq_req)
    begin
      taken_vec <= irq_vec;
      taken_cnt <= taken_cnt + 8'h01;
    end
  end
endmodule : irq_core_model
`default_nettype wire

// ==== tb/tb_three_level_irq_controller.sv ====
// Purpose: self-checking bench of the interrupt controller
// Assumes: core model acks on request of the bench
// Notes: AHB-Lite single word transfers with an idle cycle between
`default_nettype none
module tb_three_level_irq_controller;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, srst, hsel, hwrite, hreadyout, hresp, timer0_ovf, timer1_ovf, timer2_ovf, wdog_evt;
  logic bkpt_evt, vector_ack, irq_req, irq_out, ack_go;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, serial0_evt, serial1_evt, ack_dly;
  logic [5:0] ext_pin_n;
  logic [7:0] aux_evt, irq_vec, taken_vec, taken_cnt, cnt0, ev;
  logic [7:0] fa [9] = '{8'h00, 8'h08, 8'h10, 8'h14, 8'h18, 8'h28, 8'h2C, 8'h30, 8'h34};
  logic [3:0] irq_num, irq_src;
  int error_cnt, samples_checked, cyc_cnt, i, j;

  three_level_irq_controller dut_u (.sys_clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .ext_pin_n, .timer0_ovf, .timer1_ovf,
    .timer2_ovf, .serial0_evt, .serial1_evt, .wdog_evt, .bkpt_evt, .aux_evt, .vector_ack, .irq_req,
    .irq_vec, .irq_num, .irq_src, .irq_out);
  irq_core_model core_u (.sys_clk, .srst, .irq_req, .irq_vec, .ack_go, .ack_dly, .vector_ack,
    .taken_vec, .taken_cnt);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [3:0] num_of(input int k);
    return (k == 0) ? 4'h6 : (k < 7) ? 4'(k - 1) : 4'(k);
  endfunction : num_of
  function automatic logic [31:0] vec_of(input int k);
    return {24'h0, 1'b0, num_of(k), 3'h3};
  endfunction : vec_of
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  // address phase, then data phase, each held until hready
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask : ahb
  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc
  // one-cycle event of source k, 13 is the breakpoint
  task stim(input int k);
    @(posedge sys_clk);
    case (k)
      1, 3, 8, 9, 10, 11: ext_pin_n <= ~((k == 1) ? 6'h01 : (k == 3) ? 6'h02 : 6'h01 << (k - 6));
      2: timer0_ovf <= 1'b1;
      4: timer1_ovf <= 1'b1;
      5: serial0_evt <= 2'h1 << $urandom_range(1);
      6: timer2_ovf <= 1'b1;
      7: serial1_evt <= 2'h1 << $urandom_range(1);
      12: wdog_evt <= 1'b1;
      default: bkpt_evt <= 1'b1;
    endcase
    @(posedge sys_clk);
    ext_pin_n <= 6'h3F;
    {timer0_ovf, timer1_ovf, timer2_ovf, wdog_evt, bkpt_evt} <= 5'h00;
    {serial0_evt, serial1_evt} <= 4'h0;
  endtask : stim
  task take(input logic [7:0] v);
    cnt0 = taken_cnt;
    ack_go <= 1'b1;
    while (taken_cnt === cnt0) cyc(1);
    ack_go <= 1'b0;
    chk({24'h0, taken_vec}, {24'h0, v});
  endtask : take
  // flags and priorities back to zero, externals 0/1 on edges
  task clear_flags;
    for (int n = 0; n < 9; n++) wr(fa[n], (n == 0) ? 32'h05 : 32'h00);
  endtask : clear_flags

  // ---------------------------------------------------------------
  // clock, timeout and test sequence
  // ---------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 20000)
    begin
      error_cnt++;
      $display("Error at %0t: timeout", $time);
      end_sim();
    end
  end
  initial
  begin
    {srst, hsel, hwrite, ack_go} = 4'h8;
    {haddr, hwdata, htrans, ack_dly} = '0;
    {timer0_ovf, timer1_ovf, timer2_ovf, wdog_evt, bkpt_evt, serial0_evt, serial1_evt} = '0;
    ext_pin_n = 6'h3F;
    aux_evt = 8'h00;
    void'($urandom(32'h24f9));
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    cyc(2);
    for (i = 0; i < 68; i += 4) rdc(8'(i), 32'h0);
    wr(8'h40, 32'hFF);
    rdc(8'h40, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("test reset done");
    wr(8'h04, 32'hFF);
    wr(8'h0C, 32'h1F);
    clear_flags();
    for (i = 1; i < 13; i++)
    begin
      ack_dly <= 2'($urandom_range(3));
      stim(i);
      cyc(4);
      chk({31'h0, irq_req}, 32'h1);
      chk(irq_vec, vec_of(i));
      chk({irq_num, irq_src}, {num_of(i), 4'(i)});
      if (i >= 8) rdc((i == 12) ? 8'h18 : 8'h14, (i == 12) ? 32'h08 : 32'h1 << (i - 4));
      take(vec_of(i));
      cyc(3);
      chk({31'h0, irq_req}, 32'(!(i inside {1, 2, 3, 4, 8, 9, 10, 11})));
      clear_flags();
    end
    $display("test vectors done");
    wr(8'h04, 32'h02);
    stim(2);
    cyc(4);
    chk({31'h0, irq_req}, 32'h0);
    wr(8'h04, 32'h82);
    cyc(3);
    chk(irq_vec, 32'h0B);
    take(8'h0B);
    wr(8'h04, 32'hFF);
    for (int n = 0; n < 6; n++)
    begin
      i = $urandom_range(11, 1);
      j = $urandom_range(12, i + 1);
      stim(i);
      stim(j);
      cyc(3);
      chk(irq_vec, vec_of(i));
      wr((j < 8) ? 8'h08 : 8'h10, 32'h1 << ((j < 8) ? j - 1 : j - 8));
      cyc(3);
      chk(irq_vec, vec_of(j));
      clear_flags();
    end
    $display("test order done");
    wr(8'h04, 32'h00);
    for (i = 0; i < 8; i++)
    begin
      ev = 8'($urandom) | (8'h01 << i);
      wr(8'h1C, 32'h1 << i);
      wr(8'h18, 32'h20);
      aux_evt <= ev & ~(8'h01 << i);
      cyc(3);
      chk({31'h0, irq_req}, 32'h0);
      aux_evt <= ev;
      cyc(3);
      chk({irq_vec, irq_num}, {8'h33, 4'h6});
      rdc(8'h18, 32'h30);
      rdc(8'h1C, {24'h0, ev});
      rdc(8'h20, 32'h1 << i);
      wr(8'h24, 32'h1);
      rdc(8'h20, {24'h0, ev});
      rdc(8'h1C, 32'h1 << i);
      wr(8'h24, 32'h0);
      wr(8'h18, 32'h00);
      cyc(2);
      chk({31'h0, irq_req}, 32'h0);
    end
    aux_evt <= 8'h00;
    $display("test aux done");
    wr(8'h04, 32'h82);
    wr(8'h08, 32'h02);
    stim(2);
    wr(8'h28, 32'h01);
    wr(8'h18, 32'h20);
    stim(13);
    cyc(3);
    chk(irq_vec, 32'h33);
    rdc(8'h28, 32'h81);
    wr(8'h28, 32'h01);
    cyc(3);
    chk(irq_vec, 32'h0B);
    take(8'h0B);
    clear_flags();
    wr(8'h00, 32'h04);
    wr(8'h04, 32'h81);
    ext_pin_n <= 6'h3E;
    cyc(3);
    rdc(8'h00, 32'h06);
    take(8'h03);
    cyc(3);
    chk({31'h0, irq_req}, 32'h1);
    ext_pin_n <= 6'h3F;
    cyc(3);
    chk({31'h0, irq_req}, 32'h0);
    $display("test breakpoint and level done");
    wr(8'h04, 32'hA0);
    wr(8'h38, 32'h1FFF);
    wr(8'h3C, 32'h40);
    stim(6);
    cyc(3);
    chk({31'h0, irq_out}, 32'h1);
    rdc(8'h38, 32'h40);
    wr(8'h3C, 32'h0);
    cyc(2);
    chk({31'h0, irq_out}, 32'h0);
    wr(8'h3C, 32'h40);
    wr(8'h38, 32'h40);
    cyc(2);
    chk({31'h0, irq_out}, 32'h0);
    rdc(8'h38, 32'h0);
    $display("test status done");
    end_sim();
  end
endmodule : tb_three_level_irq_controller
`default_nettype wire
